// [shared/smr_params.svh]
// offsets, field positions, reset values and the embedding enable code of the signal monitor registers
`ifndef SMR_PARAMS_SVH
`define SMR_PARAMS_SVH
`define SMR_ADDR_SYNC_CTRL    12'h26f
`define SMR_ADDR_MON_CTRL     12'h270
`define SMR_ADDR_PERIOD_LOW   12'h271
`define SMR_ADDR_PERIOD_MID   12'h272
`define SMR_ADDR_PERIOD_HIGH  12'h273
`define SMR_ADDR_RESULT_CTRL  12'h274
`define SMR_ADDR_RESULT_LOW   12'h275
`define SMR_ADDR_RESULT_MID   12'h276
`define SMR_ADDR_RESULT_HIGH  12'h277
`define SMR_ADDR_PERIOD_CNT   12'h278
`define SMR_ADDR_EMBED_CTRL   12'h279
`define SMR_ADDR_EMBED_SRC    12'h27a
`define SMR_RST_PERIOD_LOW    8'h80
`define SMR_RST_PERIOD_MID    8'h00
`define SMR_RST_PERIOD_HIGH   8'h00
`define SMR_RST_RESULT_SEL    1'h1
`define SMR_BIT_UPDATE        4
`define SMR_BIT_RESULT_SEL    0
`define SMR_BIT_PEAK_EN       1
`define SMR_EMBED_ENABLE      2'h1
`define SMR_PEAK_LSB          7
`endif

// [shared/smr_pkg.sv]
// types of the signal monitor register bank
package smr_pkg;
	typedef enum logic [1:0]
	{
		SMR_SYNC_OFF        = 2'b00,
		SMR_SYNC_CONTINUOUS = 2'b01,
		SMR_SYNC_ONESHOT    = 2'b10,
		SMR_SYNC_ONESHOT_B  = 2'b11
	} smr_sync_e;

	typedef struct packed
	{
		smr_sync_e   sync_mode;
		logic        sync_armed;
		logic        peak_en;
		logic [23:0] period;
		logic        result_sel;
		logic [19:0] result;
		logic [7:0]  period_cnt_snap;
		logic [1:0]  embed_ctrl;
		logic        embed_peak;
		logic [23:0] counter;
		logic [12:0] peak;
		logic [12:0] peak_last;
		logic [7:0]  rdata;
		logic        embed_en;
		logic        sync_done;
	} smr_state_s;
endpackage

// [hdl/smr_signal_monitor_regs.sv]
// signal monitor register bank with period counter and peak detector
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "smr_params.svh"

module smr_signal_monitor_regs
	import smr_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic [12:0] sample_i,
	input  wire logic        sample_valid_i,
	input  wire logic        sync_i,
	output logic             embed_en_o,
	output logic             sync_done_o
);

	smr_state_s st_ff;
	smr_state_s nxt_st;

	// magnitude of a two's complement sample, saturating the most negative code
	function automatic logic [12:0] smr_abs(input logic [12:0] s);
		logic [12:0] neg;
		neg = 13'h0000 - s;
		if (!s[12])
			smr_abs = s;
		else if (s == 13'h1000)
			smr_abs = 13'h0fff;
		else
			smr_abs = neg;
	endfunction

	logic [12:0] mag;
	logic        wr_hit_update;
	logic        expire;

	// sample magnitude and period end; period zero is treated as one cycle
	assign mag           = smr_abs(sample_i);
	assign expire        = (st_ff.counter + 24'h000001 >= st_ff.period);
	assign wr_hit_update = wr_i && (addr_i == `SMR_ADDR_RESULT_CTRL)
		&& wdata_i[`SMR_BIT_UPDATE];

	// next state: register writes, counter, peak search, snapshot, read mux
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.sync_done = 1'b0;
		if (wr_i)
		begin
			unique case (addr_i)
				`SMR_ADDR_SYNC_CTRL:
				begin
					nxt_st.sync_mode  = smr_sync_e'(wdata_i[1:0]);
					nxt_st.sync_armed = 1'b1;
				end
				`SMR_ADDR_MON_CTRL:   nxt_st.peak_en = wdata_i[`SMR_BIT_PEAK_EN];
				`SMR_ADDR_PERIOD_LOW: nxt_st.period[7:0] = wdata_i;
				`SMR_ADDR_PERIOD_MID: nxt_st.period[15:8] = wdata_i;
				`SMR_ADDR_PERIOD_HIGH: nxt_st.period[23:16] = wdata_i;
				`SMR_ADDR_RESULT_CTRL: nxt_st.result_sel = wdata_i[`SMR_BIT_RESULT_SEL];
				`SMR_ADDR_EMBED_CTRL: nxt_st.embed_ctrl = wdata_i[1:0];
				`SMR_ADDR_EMBED_SRC:  nxt_st.embed_peak = wdata_i[1];
				default: ; // read-only and unmapped writes ignored
			endcase
		end

		// period counter with optional realignment on the external sync pulse
		if (sync_i && (st_ff.sync_mode == SMR_SYNC_CONTINUOUS
			|| (st_ff.sync_mode[1] && st_ff.sync_armed)))
		begin
			nxt_st.counter   = 24'h000000;
			nxt_st.peak      = 13'h0000;
			nxt_st.sync_done = 1'b1;
			// a rearming write in the same cycle wins over the spent shot
			if (st_ff.sync_mode[1] && !(wr_i && addr_i == `SMR_ADDR_SYNC_CTRL))
				nxt_st.sync_armed = 1'b0;
		end
		else if (expire)
		begin
			// restart the search so each period reports its own maximum
			nxt_st.counter   = 24'h000000;
			nxt_st.peak_last = st_ff.peak;
			nxt_st.peak      = (st_ff.peak_en && sample_valid_i) ? mag : 13'h0000;
		end
		else
		begin
			nxt_st.counter = st_ff.counter + 24'h000001;
			if (st_ff.peak_en && sample_valid_i && mag > st_ff.peak)
				nxt_st.peak = mag;
		end
		if (!st_ff.peak_en)
			nxt_st.peak = 13'h0000;

		// snapshot only on request; the bit itself is never stored
		if (wr_hit_update)
		begin
			if (st_ff.result_sel)
				nxt_st.result = {st_ff.peak_last, 7'h00};
			else
				nxt_st.result = 20'h00000;
			nxt_st.period_cnt_snap = st_ff.counter[7:0];
		end

		nxt_st.embed_en = (st_ff.embed_ctrl == `SMR_EMBED_ENABLE) && st_ff.embed_peak
			&& st_ff.peak_en;

		// read data appear the cycle after the read strobe
		nxt_st.rdata = 8'h00;
		if (rd_i)
		begin
			unique case (addr_i)
				`SMR_ADDR_SYNC_CTRL:   nxt_st.rdata = {6'h00, st_ff.sync_mode};
				`SMR_ADDR_MON_CTRL:    nxt_st.rdata = {6'h00, st_ff.peak_en, 1'b0};
				`SMR_ADDR_PERIOD_LOW:  nxt_st.rdata = st_ff.period[7:0];
				`SMR_ADDR_PERIOD_MID:  nxt_st.rdata = st_ff.period[15:8];
				`SMR_ADDR_PERIOD_HIGH: nxt_st.rdata = st_ff.period[23:16];
				`SMR_ADDR_RESULT_CTRL: nxt_st.rdata = {7'h00, st_ff.result_sel};
				`SMR_ADDR_RESULT_LOW:  nxt_st.rdata = st_ff.result[7:0];
				`SMR_ADDR_RESULT_MID:  nxt_st.rdata = st_ff.result[15:8];
				`SMR_ADDR_RESULT_HIGH: nxt_st.rdata = {4'h0, st_ff.result[19:16]};
				`SMR_ADDR_PERIOD_CNT:  nxt_st.rdata = st_ff.period_cnt_snap;
				`SMR_ADDR_EMBED_CTRL:  nxt_st.rdata = {6'h00, st_ff.embed_ctrl};
				`SMR_ADDR_EMBED_SRC:   nxt_st.rdata = {6'h00, st_ff.embed_peak, 1'b0};
				default:               nxt_st.rdata = 8'h00;
			endcase
		end
	end

	// state register; reset gives documented defaults
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_ff            <= '0;
			st_ff.period     <= {`SMR_RST_PERIOD_HIGH, `SMR_RST_PERIOD_MID,
				`SMR_RST_PERIOD_LOW};
			st_ff.result_sel <= `SMR_RST_RESULT_SEL;
		end
		else
			st_ff <= nxt_st;
	end

	assign rdata_o     = st_ff.rdata;
	assign embed_en_o  = st_ff.embed_en;
	assign sync_done_o = st_ff.sync_done;

	// snapshot stays put without an update request
	a_result_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!wr_hit_update |=> $stable(st_ff.result) && $stable(st_ff.period_cnt_snap))
		else $error("result changed without update");

	a_result_peak: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_hit_update && st_ff.result_sel |=> st_ff.result == {$past(st_ff.peak_last), 7'h00})
		else $error("peak snapshot wrong");

	a_cnt_snap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_hit_update |=> st_ff.period_cnt_snap == $past(st_ff.counter[7:0]))
		else $error("period count snapshot wrong");

	sequence s_rd_high;
		rd_i && addr_i == `SMR_ADDR_RESULT_HIGH;
	endsequence
	a_high_nibble: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_rd_high |=> rdata_o[7:4] == 4'h0 && rdata_o[3:0] == $past(st_ff.result[19:16]))
		else $error("result high read wrong");

	a_update_self: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == `SMR_ADDR_RESULT_CTRL |=> rdata_o[`SMR_BIT_UPDATE] == 1'b0)
		else $error("update bit reads set");

	a_period_mid: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == `SMR_ADDR_PERIOD_MID |=> st_ff.period[15:8] == $past(wdata_i))
		else $error("period mid not written");

	a_peak_max: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st_ff.peak_en && sample_valid_i && !expire && !sync_i && mag > st_ff.peak
		|=> st_ff.peak == $past(mag))
		else $error("peak not tracked");

	a_peak_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!st_ff.peak_en ##1 !st_ff.peak_en |-> st_ff.peak == 13'h0000)
		else $error("peak active while disabled");

	a_embed_en: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!st_ff.embed_peak |=> !embed_en_o)
		else $error("embedding without peak source");

	a_sync_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st_ff.sync_mode == SMR_SYNC_OFF |=> !sync_done_o)
		else $error("sync taken while off");

	// every writable byte lands the next cycle
	a_period_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == `SMR_ADDR_PERIOD_LOW |=> st_ff.period[7:0] == $past(wdata_i))
		else $error("period low not written");

	a_period_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == `SMR_ADDR_PERIOD_HIGH |=> st_ff.period[23:16] == $past(wdata_i))
		else $error("period high not written");

	a_select_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == `SMR_ADDR_RESULT_CTRL
		|=> st_ff.result_sel == $past(wdata_i[`SMR_BIT_RESULT_SEL]))
		else $error("result select not written");

	a_peak_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == `SMR_ADDR_MON_CTRL
		|=> st_ff.peak_en == $past(wdata_i[`SMR_BIT_PEAK_EN]))
		else $error("peak enable not written");

	a_embed_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == `SMR_ADDR_EMBED_CTRL |=> st_ff.embed_ctrl == $past(wdata_i[1:0]))
		else $error("embedding control not written");

	a_source_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == `SMR_ADDR_EMBED_SRC |=> st_ff.embed_peak == $past(wdata_i[1]))
		else $error("embedding source not written");

	// reserved select snapshots zero
	a_result_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_hit_update && !st_ff.result_sel |=> st_ff.result == 20'h00000)
		else $error("reserved select gave data");

	// snapshot bytes read back one cycle after the strobe
	sequence s_rd_low;
		rd_i && addr_i == `SMR_ADDR_RESULT_LOW;
	endsequence
	sequence s_rd_mid;
		rd_i && addr_i == `SMR_ADDR_RESULT_MID;
	endsequence
	sequence s_rd_cnt;
		rd_i && addr_i == `SMR_ADDR_PERIOD_CNT;
	endsequence
	a_read_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_rd_low |=> rdata_o == $past(st_ff.result[7:0]))
		else $error("result low read wrong");

	a_read_mid: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_rd_mid |=> rdata_o == $past(st_ff.result[15:8]))
		else $error("result mid read wrong");

	a_read_cnt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_rd_cnt |=> rdata_o == $past(st_ff.period_cnt_snap))
		else $error("period count read wrong");

	// idle, unmapped and reserved bits read zero
	a_read_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data without strobe");

	a_read_unmapped: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && (addr_i < `SMR_ADDR_SYNC_CTRL || addr_i > `SMR_ADDR_EMBED_SRC)
		|=> rdata_o == 8'h00)
		else $error("unmapped read not zero");

	a_source_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == `SMR_ADDR_EMBED_SRC
		|=> rdata_o == {6'h00, $past(st_ff.embed_peak), 1'b0})
		else $error("embedding source read wrong");

	// embedding enable follows its conditions one cycle later
	a_embed_code: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st_ff.embed_ctrl != `SMR_EMBED_ENABLE |=> !embed_en_o)
		else $error("embedding on with reserved code");

	a_embed_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st_ff.embed_ctrl == `SMR_EMBED_ENABLE && st_ff.embed_peak && st_ff.peak_en
		|=> embed_en_o)
		else $error("embedding not enabled");

	// counter counts up, wraps at the period, latches the peak there
	a_count_up: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!expire && !sync_i |=> st_ff.counter == $past(st_ff.counter) + 24'h000001)
		else $error("period counter did not count");

	a_period_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		expire && !sync_i
		|=> st_ff.counter == 24'h000000 && st_ff.peak_last == $past(st_ff.peak))
		else $error("period end not handled");

	// sync: continuous on every pulse, one-shot once per arming write
	sequence s_sync_cont;
		sync_i && st_ff.sync_mode == SMR_SYNC_CONTINUOUS;
	endsequence
	sequence s_sync_shot;
		sync_i && st_ff.sync_mode[1] && st_ff.sync_armed
			&& !(wr_i && addr_i == `SMR_ADDR_SYNC_CTRL);
	endsequence
	sequence s_sync_spent;
		sync_i && st_ff.sync_mode[1] && !st_ff.sync_armed;
	endsequence
	a_sync_cont: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_sync_cont |=> sync_done_o && st_ff.counter == 24'h000000)
		else $error("continuous sync not taken");

	a_sync_disarm: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_sync_shot |=> sync_done_o && !st_ff.sync_armed)
		else $error("one-shot sync not taken once");

	a_sync_spent: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_sync_spent |=> !sync_done_o)
		else $error("spent one-shot sync taken again");

	a_sync_arm: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == `SMR_ADDR_SYNC_CTRL
		|=> st_ff.sync_armed && st_ff.sync_mode == $past(wdata_i[1:0]))
		else $error("sync mode not armed");
endmodule

// [verification/smr_signal_monitor_regs_tb_top.sv]
// self-checking bench of the signal monitor register bank
`timescale 1ns/1ps
`include "smr_params.svh"
module smr_signal_monitor_regs_tb_top;
	logic        ref_clk_i      = 1'b0;
	logic        rst_i          = 1'b1;
	logic [11:0] addr_i         = 12'h000;
	logic [7:0]  wdata_i        = 8'h00;
	logic        wr_i           = 1'b0;
	logic        rd_i           = 1'b0;
	logic [12:0] sample_i       = 13'h0000;
	logic        sample_valid_i = 1'b0;
	logic        sync_i         = 1'b0;
	logic [7:0]  rdata_o;
	logic        embed_en_o;
	logic        sync_done_o;
	int          err_total      = 0;
	int          cmp_count      = 0;
	int          pk             = 0;
	int          cnt            = 0;
	int          k;
	logic [7:0]  mdl [12'h26f:12'h27a];
	logic [19:0] res;

	smr_signal_monitor_regs u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i),
		.sample_valid_i(sample_valid_i), .sync_i(sync_i), .embed_en_o(embed_en_o),
		.sync_done_o(sync_done_o));

	// 40 MHz clock
	initial
	begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// writable bits of each register; all others are dropped by the model
	function automatic logic [7:0] wmask(input int a);
		case (a)
			'h26f, 'h279: return 8'h03;
			'h270, 'h27a: return 8'h02;
			'h271, 'h272, 'h273: return 8'hff;
			'h274: return 8'h01;
			default: return 8'h00;
		endcase
	endfunction

	// model snapshots before taking the new select bit, as the design does
	task automatic wr(input int a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= 12'(a);
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		if (a == 'h274 && d[4])
		begin
			res = mdl['h274][0] ? {13'(pk), 7'h00} : 20'h00000;
			mdl['h275] = res[7:0];
			mdl['h276] = res[15:8];
			mdl['h277] = {4'h0, res[19:16]};
			mdl['h278] = 8'(cnt);
		end
		if (a >= 'h26f && a <= 'h27a && wmask(a) != 8'h00)
			mdl[a] = d & wmask(a);
	endtask

	// read data is looked at in the single cycle where it stands
	task automatic rd(input int a);
		@(posedge ref_clk_i);
		addr_i <= 12'(a);
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("rdata", rdata_o, (a >= 'h26f && a <= 'h27a) ? mdl[a] : 8'h00);
	endtask

	task automatic rd_all();
		for (int a = 'h26f; a <= 'h27b; a++) rd(a);
	endtask

	// one sync pulse; the done flag is looked at in the cycle where it stands
	task automatic sync_pulse(input logic [7:0] exp);
		@(posedge ref_clk_i);
		sync_i <= 1'b1;
		@(posedge ref_clk_i);
		sync_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("sync_done", {7'h00, sync_done_o}, exp);
	endtask

	task automatic summarize();
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (100000) @(posedge ref_clk_i);
		err_total++;
		summarize();
	end

	initial
	begin
		void'($urandom(32'haeea));
		foreach (mdl[i]) mdl[i] = 8'h00;
		mdl['h271] = 8'h80;
		mdl['h274] = 8'h01;
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd_all();
		// random writes everywhere, read-only and unmapped places included
		for (int a = 'h26f; a <= 'h27b; a++) wr(a, 8'($urandom) & 8'hef);
		rd_all();
		foreach (mdl[i]) if (wmask(i) != 8'h00) wr(i, 8'h00);
		// embedding enable with control, source and detector all on, and off again with control code 2
		wr('h279, 8'h01);
		wr('h27a, 8'h02);
		wr('h270, 8'h02);
		wr('h274, 8'h01);
		repeat (2) @(negedge ref_clk_i);
		chk("embed", {7'h0, embed_en_o}, 8'h01);
		wr('h279, 8'h02);
		repeat (2) @(negedge ref_clk_i);
		chk("embed", {7'h0, embed_en_o}, 8'h00);
		// short period, continuous sync; constant magnitude so each peak is known
		wr(12'h271, 8'h08);
		wr(12'h26f, 8'h01);
		sample_valid_i <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			k = 1 + ($urandom % 4095);
			sample_i <= 13'(-k);
			// last round with the detector off: its snapshot must read zero
			if (i == 4)
				wr(12'h270, 8'h00);
			repeat (30) @(posedge ref_clk_i);
			rd_all();
			pk = (i == 4) ? 0 : k;
			sync_pulse(8'h01);
			// the sync restarts a period of 8, so the counter phase is known
			k = $urandom % 20;
			repeat (k) @(posedge ref_clk_i);
			cnt = (k + 1) % 8;
			// round 2 also clears the select, so round 3 snapshots zero
			wr(12'h274, (i == 2) ? 8'h10 : 8'h11);
			rd_all();
		end
		// one-shot sync is taken once per arming write, never when off
		wr(12'h26f, 8'h02);
		sync_pulse(8'h01);
		sync_pulse(8'h00);
		wr(12'h26f, 8'h00);
		sync_pulse(8'h00);
		summarize();
	end
endmodule
